// ==== sro_pkg.sv ====
//------------------------------------------------------------------------
// constants and types of the start-up residual overvoltage function
//------------------------------------------------------------------------
// Notes on behaviour
// - a block input held high disables the function: no start, no trip.
// - the final trip combines internal start and trip with the settings.
// - start-only setting, default false, keeps start and suppresses trip.
// - trip delay 0..60000 ms, default 200, counted from fault onset.
// - start asserts about 2.5 signal periods after pickup appears.
// - start and trip drop about 3 signal periods after pickup vanishes.
// - the measured value comes from the fourth voltage input channel.
// - general start and general trip outputs; internal start and trip shown as live status.
// - every on and off edge of start and trip gives an event pulse, except a drop forced by reset.
// - start while residual exceeds pickup, 2..60 percent, default 30.
// - peak-to-peak input is already scaled as RMS of a sinusoid.
package sro_pkg;

    //--------------------------------------------------------------------
    // measurement
    //--------------------------------------------------------------------
    localparam int MEAS_W = 16; // residual value, units of 0.1 % rated
    localparam int CH_COUNT = 4;
    localparam logic [1:0] MEAS_CH = 2'h3; // fourth voltage channel
    localparam logic [15:0] MEAS_PER_PCT = 16'h000a;

    //--------------------------------------------------------------------
    // settings
    //--------------------------------------------------------------------
    localparam int PICKUP_W = 6;
    localparam logic [5:0] PICKUP_MIN = 6'h02;
    localparam logic [5:0] PICKUP_MAX = 6'h3c;
    localparam logic [5:0] PICKUP_DEFAULT = 6'h1e;
    localparam int DELAY_W = 16;
    localparam logic [15:0] DELAY_MAX = 16'hea60;
    localparam logic [15:0] DELAY_DEFAULT = 16'h00c8;
    localparam logic OPER_DEFAULT = 1'b0;
    localparam logic START_ONLY_DEFAULT = 1'b0;

    //--------------------------------------------------------------------
    // timing
    //--------------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int MS_PER_S = 1000;
    localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;
    localparam int MS_CNT_W = 17;
    localparam int PERIOD_W = 24; // clock cycles per signal period
    localparam int LIM_W = PERIOD_W + 3;
    localparam int OPERATE_HALF_PERIODS = 5; // 2.5 periods
    localparam int RESET_PERIODS = 3;

    //--------------------------------------------------------------------
    // reset values
    //--------------------------------------------------------------------
    localparam logic OUT_RST = 1'b0;
    localparam logic [15:0] ELAPSED_RST = 16'h0000;
    localparam logic [16:0] MS_CNT_RST = 17'h00000;
    localparam logic [15:0] MEAS_RST = 16'h0000;
    localparam logic [26:0] SPAN_RST = 27'h0000000;

    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_TRIP} sro_state_type;

endpackage

// ==== sro_span_if.sv ====
//------------------------------------------------------------------------
// request and answer of one span timer
//------------------------------------------------------------------------
interface sro_span_if;
    import sro_pkg::*;
    logic run;
    logic [LIM_W-1:0] limit;
    logic done;
    modport owner (output run, output limit, input done);
    modport timer (input run, input limit, output done);
endinterface

// ==== sro_span_timer.sv ====
//------------------------------------------------------------------------
// span timer: done once run has been held for limit cycles
//------------------------------------------------------------------------
module sro_span_timer
    import sro_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    sro_span_if.timer span
);

    logic [LIM_W-1:0] cnt_q;
    logic done_q;

    // count while run is held, restart when it drops
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in || !span.run)
        begin
            cnt_q <= SPAN_RST;
        end
        else if (cnt_q < span.limit)
        begin
            cnt_q <= cnt_q + LIM_W'(1);
        end
    end

    // done is a level, held while run stays high
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            done_q <= OUT_RST;
        end
        else
        begin
            done_q <= span.run && (cnt_q >= span.limit);
        end
    end

    assign span.done = done_q;

    //--------------------------------------------------------------------
    // checks
    //--------------------------------------------------------------------
    span_done_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        $rose(done_q) |-> $past(span.run) && ($past(cnt_q) >= $past(span.limit)))
        else $error("span timer finished before its limit");

    span_drop_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !span.run |=> !done_q)
        else $error("span timer done without run");

endmodule

// ==== sro_trip_top.sv ====
//------------------------------------------------------------------------
// start-up residual overvoltage: definite time start and trip
//------------------------------------------------------------------------
module sro_trip_top
    import sro_pkg::*;
#(
    parameter int CYCLES_PER_MS_P = CYCLES_PER_MS
)
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [CH_COUNT-1:0][MEAS_W-1:0] vt_pp_in,
    input wire logic [PERIOD_W-1:0] signal_period_in,
    input wire logic block_input_in,
    input wire logic operation_on_in,
    input wire logic start_only_in,
    input wire logic [PICKUP_W-1:0] pickup_pct_in,
    input wire logic [DELAY_W-1:0] trip_delay_ms_in,
    output logic internal_start_status_out,
    output logic internal_trip_status_out,
    output logic general_start_out,
    output logic general_trip_out,
    output logic start_on_event_out,
    output logic start_off_event_out,
    output logic trip_on_event_out,
    output logic trip_off_event_out
);

    //--------------------------------------------------------------------
    // declarations
    //--------------------------------------------------------------------
    sro_state_type state_q, state_d;
    logic [MEAS_W-1:0] meas_q;
    logic [MS_CNT_W-1:0] ms_cnt_q;
    logic [DELAY_W-1:0] elapsed_q;
    logic [PICKUP_W-1:0] pickup_eff;
    logic [DELAY_W-1:0] delay_eff;
    logic [MEAS_W-1:0] thresh;
    logic enabled;
    logic raw_pick;
    logic timing;
    logic delay_reached;
    logic gen_start_d, gen_trip_d;
    logic int_start_q, int_trip_q, gen_start_q, gen_trip_q;
    logic st_on_q, st_off_q, tr_on_q, tr_off_q;

    sro_span_if op_if ();
    sro_span_if drop_if ();

    //--------------------------------------------------------------------
    // settings and pickup
    //--------------------------------------------------------------------
    // function enabled only when on and not blocked
    assign enabled = operation_on_in && !block_input_in;

    // clamp settings to their legal ranges
    always_comb
    begin
        if (pickup_pct_in < PICKUP_MIN)
        begin
            pickup_eff = PICKUP_MIN;
        end
        else if (pickup_pct_in > PICKUP_MAX)
        begin
            pickup_eff = PICKUP_MAX;
        end
        else
        begin
            pickup_eff = pickup_pct_in;
        end
        delay_eff = (trip_delay_ms_in > DELAY_MAX) ? DELAY_MAX : trip_delay_ms_in;
    end

    // sample the fourth channel, already RMS-scaled peak-to-peak
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            meas_q <= MEAS_RST;
        end
        else
        begin
            meas_q <= vt_pp_in[MEAS_CH];
        end
    end

    // compare against pickup in tenths of a percent
    assign thresh = {10'h000, pickup_eff} * MEAS_PER_PCT;
    assign raw_pick = enabled && (meas_q > thresh);

    //--------------------------------------------------------------------
    // operate and reset filters
    //--------------------------------------------------------------------
    // operate after 2.5 periods, reset after 3 periods
    assign op_if.run = raw_pick && (state_q == ST_IDLE);
    assign op_if.limit = LIM_W'(({3'h0, signal_period_in} * LIM_W'(OPERATE_HALF_PERIODS)) >> 1);
    assign drop_if.run = enabled && !raw_pick && (state_q != ST_IDLE);
    assign drop_if.limit = LIM_W'({3'h0, signal_period_in} * LIM_W'(RESET_PERIODS));

    sro_span_timer u_op_timer (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .span(op_if.timer)
    );

    sro_span_timer u_drop_timer (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .span(drop_if.timer)
    );

    //--------------------------------------------------------------------
    // definite delay, counted from fault onset
    //--------------------------------------------------------------------
    assign timing = enabled && (raw_pick || state_q != ST_IDLE);
    assign delay_reached = elapsed_q >= delay_eff;

    // millisecond prescaler
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in || !timing)
        begin
            ms_cnt_q <= MS_CNT_RST;
        end
        else if (ms_cnt_q == MS_CNT_W'(CYCLES_PER_MS_P - 1))
        begin
            ms_cnt_q <= MS_CNT_RST;
        end
        else
        begin
            ms_cnt_q <= ms_cnt_q + MS_CNT_W'(1);
        end
    end

    // elapsed milliseconds, saturating at the maximum delay
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in || !timing)
        begin
            elapsed_q <= ELAPSED_RST;
        end
        else if (ms_cnt_q == MS_CNT_W'(CYCLES_PER_MS_P - 1) && elapsed_q < DELAY_MAX)
        begin
            elapsed_q <= elapsed_q + DELAY_W'(1);
        end
    end

    //--------------------------------------------------------------------
    // decision state
    //--------------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:
            begin
                if (enabled && op_if.done)
                begin
                    state_d = ST_START;
                end
            end
            ST_START:
            begin
                if (!enabled || drop_if.done)
                begin
                    state_d = ST_IDLE;
                end
                else if (delay_reached)
                begin
                    state_d = ST_TRIP;
                end
            end
            ST_TRIP:
            begin
                if (!enabled || drop_if.done)
                begin
                    state_d = ST_IDLE;
                end
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            state_q <= ST_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    //--------------------------------------------------------------------
    // outputs and events
    //--------------------------------------------------------------------
    // general trip masked by start-only
    assign gen_start_d = (state_d != ST_IDLE);
    assign gen_trip_d = (state_d == ST_TRIP) && !start_only_in;

    // live status and general outputs
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            int_start_q <= OUT_RST;
            int_trip_q <= OUT_RST;
            gen_start_q <= OUT_RST;
            gen_trip_q <= OUT_RST;
        end
        else
        begin
            int_start_q <= (state_d != ST_IDLE);
            int_trip_q <= (state_d == ST_TRIP);
            gen_start_q <= gen_start_d;
            gen_trip_q <= gen_trip_d;
        end
    end

    // one-cycle pulses on each edge of the general outputs, except a fall forced by reset
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            st_on_q <= OUT_RST;
            st_off_q <= OUT_RST;
            tr_on_q <= OUT_RST;
            tr_off_q <= OUT_RST;
        end
        else
        begin
            st_on_q <= gen_start_d && !gen_start_q;
            st_off_q <= !gen_start_d && gen_start_q;
            tr_on_q <= gen_trip_d && !gen_trip_q;
            tr_off_q <= !gen_trip_d && gen_trip_q;
        end
    end

    assign internal_start_status_out = int_start_q;
    assign internal_trip_status_out = int_trip_q;
    assign general_start_out = gen_start_q;
    assign general_trip_out = gen_trip_q;
    assign start_on_event_out = st_on_q;
    assign start_off_event_out = st_off_q;
    assign trip_on_event_out = tr_on_q;
    assign trip_off_event_out = tr_off_q;

    //--------------------------------------------------------------------
    // checks
    //--------------------------------------------------------------------
    block_clears_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        block_input_in |=> !general_start_out && !general_trip_out)
        else $error("output active while blocked");

    oper_off_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !operation_on_in |=> !general_start_out && elapsed_q == ELAPSED_RST)
        else $error("function active while off");

    start_only_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        start_only_in |=> !general_trip_out)
        else $error("trip issued in start-only mode");

    trip_has_start_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        general_trip_out |-> general_start_out && internal_trip_status_out)
        else $error("trip without start");

    trip_delay_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        $rose(internal_trip_status_out) |-> $past(elapsed_q) >= $past(delay_eff))
        else $error("trip before delay elapsed");

    start_operate_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        $rose(internal_start_status_out) |-> $past(op_if.done) && $past(enabled))
        else $error("start without operate time");

    start_reset_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        $fell(internal_start_status_out) && $past(enabled) |-> $past(drop_if.done))
        else $error("start dropped before reset time");

    meas_channel_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !$past(rst_in) |-> meas_q == $past(vt_pp_in[MEAS_CH]))
        else $error("wrong measurement channel");

    start_events_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        ($rose(general_start_out) |-> start_on_event_out)
        and ($fell(general_start_out) |-> start_off_event_out))
        else $error("start edge without event");

    trip_events_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        $rose(general_trip_out) |-> trip_on_event_out ##1 !trip_on_event_out)
        else $error("trip event missing or too long");

    reset_clear_a: assert property (@(posedge ref_clk_in)
        rst_in |=> !general_start_out && !general_trip_out && !start_on_event_out)
        else $error("outputs not cleared by reset");

endmodule

// ==== sro_far_model.sv ====
//------------------------------------------------------------------------
// far side: user logic equation and event list of the trip logic
//------------------------------------------------------------------------
module sro_far_model
    import sro_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic block_cmd_in,
    input wire logic start_in,
    input wire logic trip_in,
    input wire logic start_on_in,
    input wire logic start_off_in,
    input wire logic trip_on_in,
    input wire logic trip_off_in,
    output logic block_input_out,
    output int on_count_out,
    output int off_count_out,
    output int fault_count_out
);
    logic start_q;
    logic trip_q;

    // user equation result drives the block input
    assign block_input_out = block_cmd_in;

    // event list: every edge must come with its own pulse
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            start_q <= 1'b0;
            trip_q <= 1'b0;
            on_count_out <= 0;
            off_count_out <= 0;
            fault_count_out <= 0;
        end
        else
        begin
            start_q <= start_in;
            trip_q <= trip_in;
            on_count_out <= on_count_out + int'(start_on_in) + int'(trip_on_in);
            off_count_out <= off_count_out + int'(start_off_in) + int'(trip_off_in);
            if (((start_in & ~start_q) !== start_on_in) || ((~start_in & start_q) !== start_off_in)
                || ((trip_in & ~trip_q) !== trip_on_in) || ((~trip_in & trip_q) !== trip_off_in))
                fault_count_out <= fault_count_out + 1;
        end
    end
endmodule

// ==== tb.sv ====
//------------------------------------------------------------------------
// self-checking bench of the start-up residual overvoltage function
//------------------------------------------------------------------------
module tb
    import sro_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int P = 20; // signal period in clock cycles
    localparam int L = 5 * P / 2;

    typedef struct {
        logic [15:0] lvl;
        logic [5:0] pick;
        logic blk;
        logic oper;
        logic so;
        logic [15:0] dly;
        logic st;
        logic tr;
    } sro_row_type;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [CH_COUNT-1:0][MEAS_W-1:0] vt = '0;
    logic blk_cmd = 1'b0;
    logic oper = 1'b0;
    logic so = 1'b0;
    logic [PICKUP_W-1:0] pick = 6'h1e;
    logic [DELAY_W-1:0] dly = 16'h0014;
    logic [PERIOD_W-1:0] per = 24'(P); // signal period, changed once mid-run
    logic blk;
    logic i_st, i_tr, g_st, g_tr, st_on, st_off, tr_on, tr_off;
    int on_cnt, off_cnt, fault_cnt;
    int bad_count = 0;
    int tests_run = 0;
    int n, m;
    sro_row_type rows [10];

    always #5 clk = ~clk;

    sro_trip_top #(.CYCLES_PER_MS_P(10)) u_sro_trip_top (
        .ref_clk_in(clk), .rst_in(rst), .vt_pp_in(vt), .signal_period_in(per),
        .block_input_in(blk), .operation_on_in(oper), .start_only_in(so),
        .pickup_pct_in(pick), .trip_delay_ms_in(dly),
        .internal_start_status_out(i_st), .internal_trip_status_out(i_tr),
        .general_start_out(g_st), .general_trip_out(g_tr),
        .start_on_event_out(st_on), .start_off_event_out(st_off),
        .trip_on_event_out(tr_on), .trip_off_event_out(tr_off));

    sro_far_model u_sro_far_model (
        .ref_clk_in(clk), .rst_in(rst), .block_cmd_in(blk_cmd),
        .start_in(g_st), .trip_in(g_tr), .start_on_in(st_on), .start_off_in(st_off),
        .trip_on_in(tr_on), .trip_off_in(tr_off), .block_input_out(blk),
        .on_count_out(on_cnt), .off_count_out(off_cnt), .fault_count_out(fault_cnt));

    //--------------------------------------------------------------------
    // helpers
    //--------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apply(input logic [15:0] l, input logic [5:0] p, input logic b,
                         input logic o, input logic s, input logic [15:0] d);
        @(negedge clk);
        vt = {l, 16'hffff, 16'hffff, 16'hffff}; // other channels held high
        pick = p;
        blk_cmd = b;
        oper = o;
        so = s;
        dly = d;
    endtask

    // count falling edges until the chosen output shows the level
    task automatic wait_for(input bit trip_sel, input logic lvl, output int c);
        c = 0;
        while (((trip_sel ? g_tr : g_st) !== lvl) && (c < 1000))
        begin
            @(negedge clk);
            c++;
        end
    endtask

    task automatic settle();
        apply(16'h0000, 6'h1e, 1'b0, 1'b1, 1'b0, 16'h0014);
        repeat (100) @(negedge clk);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if ((bad_count == 0) && (tests_run > 0))
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    //--------------------------------------------------------------------
    // watchdog
    //--------------------------------------------------------------------
    initial
    begin
        repeat (60000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end

    //--------------------------------------------------------------------
    // main sequence
    //--------------------------------------------------------------------
    initial
    begin
        rows[0] = '{16'h012d, 6'h1e, 1'b0, 1'b1, 1'b0, 16'h0014, 1'b1, 1'b1};
        rows[1] = '{16'h012c, 6'h1e, 1'b0, 1'b1, 1'b0, 16'h0014, 1'b0, 1'b0};
        rows[2] = '{16'h0190, 6'h1e, 1'b1, 1'b1, 1'b0, 16'h0014, 1'b0, 1'b0};
        rows[3] = '{16'h0190, 6'h1e, 1'b0, 1'b0, 1'b0, 16'h0014, 1'b0, 1'b0};
        rows[4] = '{16'h0190, 6'h1e, 1'b0, 1'b1, 1'b1, 16'h0014, 1'b1, 1'b0};
        rows[5] = '{16'h0259, 6'h3f, 1'b0, 1'b1, 1'b0, 16'h0014, 1'b1, 1'b1};
        rows[6] = '{16'h0257, 6'h3f, 1'b0, 1'b1, 1'b0, 16'h0014, 1'b0, 1'b0};
        rows[7] = '{16'h0015, 6'h00, 1'b0, 1'b1, 1'b0, 16'h0000, 1'b1, 1'b1};
        rows[8] = '{16'h0013, 6'h00, 1'b0, 1'b1, 1'b0, 16'h0000, 1'b0, 1'b0};
        rows[9] = '{16'h0190, 6'h1e, 1'b0, 1'b1, 1'b0, 16'hffff, 1'b1, 1'b0};
        // reset held with a fault applied: outputs stay low
        apply(16'h0190, 6'h1e, 1'b0, 1'b1, 1'b0, 16'h0014);
        repeat (16) @(negedge clk);
        check({g_st, g_tr, i_st, i_tr, st_on, tr_on}, 32'h0);
        rst = 1'b0;
        settle();
        // table of cases, including out-of-range pickup and delay settings
        foreach (rows[i])
        begin
            apply(rows[i].lvl, rows[i].pick, rows[i].blk, rows[i].oper, rows[i].so, rows[i].dly);
            repeat (400) @(negedge clk);
            check({g_st, g_tr}, {rows[i].st, rows[i].tr});
            settle();
        end
        // operate time, trip delay from fault onset, then reset time
        apply(16'h0190, 6'h1e, 1'b0, 1'b1, 1'b0, 16'h0014);
        wait_for(1'b0, 1'b1, n);
        check(32'((n >= L - P) && (n <= L + P + 4)), 32'h1);
        check(32'(g_tr), 32'h0);
        wait_for(1'b1, 1'b1, m);
        check(32'((n + m >= 198) && (n + m <= 208)), 32'h1);
        apply(16'h0000, 6'h1e, 1'b0, 1'b1, 1'b0, 16'h0014);
        wait_for(1'b0, 1'b0, n);
        check(32'((n >= 2 * P) && (n <= 4 * P + 4)), 32'h1);
        check({g_tr, i_tr, i_st}, 32'h0);
        // block raised while tripped
        apply(16'h0190, 6'h1e, 1'b0, 1'b1, 1'b0, 16'h0000);
        wait_for(1'b1, 1'b1, n);
        apply(16'h0190, 6'h1e, 1'b1, 1'b1, 1'b0, 16'h0000);
        repeat (2) @(negedge clk);
        check({g_st, g_tr, i_st, i_tr}, 32'h0);
        // start-only toggled live, then operation switched off
        apply(16'h0190, 6'h1e, 1'b0, 1'b1, 1'b0, 16'h0000);
        wait_for(1'b1, 1'b1, n);
        apply(16'h0190, 6'h1e, 1'b0, 1'b1, 1'b1, 16'h0000);
        repeat (2) @(negedge clk);
        check({g_st, g_tr, i_tr}, 32'h5);
        apply(16'h0190, 6'h1e, 1'b0, 1'b0, 1'b1, 16'h0000);
        repeat (2) @(negedge clk);
        check({g_st, g_tr, i_st, i_tr}, 32'h0);
        settle();
        check(32'(fault_cnt), 32'h0);
        check(32'(on_cnt), 32'(off_cnt));
        check(32'(on_cnt > 0), 32'h1);
        // reset raised while tripped, released with a slower signal period
        apply(16'h0190, 6'h1e, 1'b0, 1'b1, 1'b0, 16'h0000);
        wait_for(1'b1, 1'b1, n);
        rst = 1'b1;
        per = 24'(2 * P);
        repeat (2) @(negedge clk);
        check({g_st, g_tr, i_st, i_tr, st_on, tr_on}, 32'h0);
        rst = 1'b0;
        wait_for(1'b0, 1'b1, n);
        check(32'((n >= 3 * P) && (n <= 7 * P + 4)), 32'h1);
        apply(16'h0000, 6'h1e, 1'b0, 1'b1, 1'b0, 16'h0000);
        wait_for(1'b0, 1'b0, n);
        check(32'((n >= 4 * P) && (n <= 8 * P + 4)), 32'h1);
        repeat (4) @(negedge clk);
        check(32'(fault_cnt), 32'h0);
        check(32'(on_cnt), 32'(off_cnt));
        report_and_stop();
    end
endmodule
